//--- src/scr_pkg.sv
package scr_pkg;

    localparam int NUM_SLOTS   = 5;
    localparam int NUM_RELAYS  = 25;
    localparam int NUM_MEAS    = 20;
    localparam int PAIR_OFFSET = 10;
    localparam int POLE_RELAY  = 23;
    localparam int SENSE_RELAY = 24;
    localparam int INPUT_RELAY = 25;
    localparam int SLOT_MIN    = 1;
    localparam int CODE_W      = 12;
    localparam int CH_W        = 5;
    localparam int SLOT_W      = 3;

    localparam int CLK_HZ      = 25_000_000;
    localparam int ID_SHOW_MS  = 500;
    localparam int ID_SHOW_CYC = ID_SHOW_MS * (CLK_HZ / 1000);

    localparam logic [4:0]  SIM_RST  = 5'h00;
    localparam logic [11:0] CODE_RST = 12'h000;

    typedef enum logic [1:0]
    {
        SCR_OP_CLOSE,
        SCR_OP_OPEN_ALL,
        SCR_OP_DESELECT,
        SCR_OP_ASSIGN
    } scr_op_t;

endpackage

//--- src/scr_code_dec.sv
`timescale 1ns/1ps

module scr_code_dec
(
    input  wire logic [11:0] code_i,
    output logic      [2:0]  slot_idx_o,
    output logic             slot_ok_o,
    output logic      [4:0]  ch_o,
    output logic             ch_ok_o
);

    logic [3:0] slot_dig;
    logic [3:0] tens_dig;
    logic [3:0] unit_dig;
    logic [7:0] ch_wide;

    assign slot_dig   = code_i[11:8];
    assign tens_dig   = code_i[7:4];
    assign unit_dig   = code_i[3:0];
    assign slot_ok_o  = (slot_dig >= 4'(scr_pkg::SLOT_MIN))
                     && (slot_dig <= 4'(scr_pkg::NUM_SLOTS));
    assign slot_idx_o = 3'(slot_dig - 4'(scr_pkg::SLOT_MIN));
    assign ch_wide    = ({4'h0, tens_dig} * 8'h0a) + {4'h0, unit_dig};
    assign ch_o       = ch_wide[4:0];
    // non-decimal digits never name a channel
    assign ch_ok_o    = (tens_dig <= 4'h9) && (unit_dig <= 4'h9)
                     && (ch_wide >= 8'h01) && (ch_wide <= 8'(scr_pkg::NUM_MEAS));

endmodule

//--- src/scr_id_seq.sv
`timescale 1ns/1ps

module scr_id_seq
#(
    parameter int SHOW_CYC = scr_pkg::ID_SHOW_CYC
)
(
    input  wire logic       mclk_i,
    input  wire logic       nrst_i,
    input  wire logic [4:0] present_i,
    output logic            busy_o,
    output logic            show_o,
    output logic      [2:0] slot_o
);

    localparam int CW = $clog2(SHOW_CYC + 1);

    typedef enum logic [1:0] {ID_WALK, ID_SHOW, ID_DONE} scr_id_state_t;

    scr_id_state_t state_reg;
    logic [2:0]    ptr_reg;
    logic [CW-1:0] cnt_reg;

    // walks the slots once after reset, lingering on each installed module
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_reg <= ID_WALK;
            ptr_reg   <= 3'h0;
            cnt_reg   <= '0;
        end
        else
        begin
            case (state_reg)
                ID_WALK:
                begin
                    cnt_reg <= '0;
                    if (ptr_reg == 3'(scr_pkg::NUM_SLOTS))
                        state_reg <= ID_DONE;
                    else if (present_i[ptr_reg])
                        state_reg <= ID_SHOW;
                    else
                        ptr_reg <= ptr_reg + 3'h1;
                end
                ID_SHOW:
                begin
                    if (cnt_reg == CW'(SHOW_CYC - 1))
                    begin
                        ptr_reg   <= ptr_reg + 3'h1;
                        state_reg <= ID_WALK;
                    end
                    else
                        cnt_reg <= cnt_reg + CW'(1);
                end
                ID_DONE:
                    state_reg <= ID_DONE;
                default:
                    state_reg <= ID_DONE;
            endcase
        end
    end

    assign busy_o = (state_reg != ID_DONE);
    assign show_o = (state_reg == ID_SHOW);
    assign slot_o = ptr_reg;

endmodule

//--- src/scr_relay_ctrl.sv
`timescale 1ns/1ps

// Summary of operation
// - only one system channel closed at once
// - nothing selected means no system channel
// - system channel closes input isolation relay
// - input isolation is relay twenty-five
// - four-wire also closes pair and sense isolation
// - sense isolation is relay twenty-four
// - four-wire also closes pole relay twenty-three
// - channels 1-10 pair with 11-20
// - new close opens previous system channel
// - non-measurement channel requests refused, relays kept
// - code is slot digit plus two digits
// - five slots chosen by slot digit
// - simulated module only into empty slot
// - simulated module assigned only over remote
// - assignment lights lamp, cleared at power-up
// - power-up shows each installed module briefly
// - four-wire refuses paired-bank channel close
// - open-all opens every relay, no system channel
module scr_relay_ctrl
#(
    parameter int NUM_SLOTS   = scr_pkg::NUM_SLOTS,
    parameter int NUM_RELAYS  = scr_pkg::NUM_RELAYS,
    parameter int ID_SHOW_CYC = scr_pkg::ID_SHOW_CYC
)
(
    input  wire logic                           mclk_i,
    input  wire logic                           nrst_i,
    input  wire logic                           req_valid_i,
    input  wire logic                           req_remote_i,
    input  wire scr_pkg::scr_op_t               req_op_i,
    input  wire logic [11:0]                    req_code_i,
    input  wire logic                           req_sim_meas_i,
    input  wire logic                           four_wire_i,
    input  wire logic [NUM_SLOTS-1:0]           module_present_i,
    input  wire logic [NUM_SLOTS-1:0]           module_meas_i,
    output logic                                req_ready_o,
    output logic                                req_done_o,
    output logic                                req_ok_o,
    output logic [NUM_SLOTS*NUM_RELAYS-1:0]     relay_o,
    output logic                                sys_valid_o,
    output logic [11:0]                         sys_code_o,
    output logic [NUM_SLOTS-1:0]                sim_lamp_o,
    output logic                                id_show_o,
    output logic [2:0]                          id_slot_o
);

    localparam int RW = NUM_SLOTS * NUM_RELAYS;

    logic                 id_busy;
    logic [2:0]           slot_idx;
    logic                 slot_ok;
    logic [4:0]           ch;
    logic                 ch_ok;
    logic                 take;
    logic                 is_close;
    logic                 is_clear;
    logic                 is_assign;
    logic [NUM_SLOTS-1:0] occupied;
    logic [NUM_SLOTS-1:0] meas_ok;
    logic                 close_ok;
    logic                 assign_ok;
    logic                 req_ok;
    logic [RW-1:0]        close_vec;
    logic [RW-1:0]        relay_reg;
    logic [RW-1:0]        relay_next;
    logic [NUM_SLOTS-1:0] slot_any;
    logic [NUM_SLOTS-1:0] spare_any;
    logic [NUM_SLOTS-1:0] sim_reg;
    logic [NUM_SLOTS-1:0] sim_meas_reg;
    logic                 sys_valid_reg;
    logic [2:0]           sys_slot_reg;
    logic [4:0]           sys_ch_reg;
    logic                 sys_4w_reg;
    logic [11:0]          sys_code_reg;
    logic                 done_reg;
    logic                 ok_reg;

    scr_code_dec scr_code_dec_inst
    (
        .code_i     (req_code_i),
        .slot_idx_o (slot_idx),
        .slot_ok_o  (slot_ok),
        .ch_o       (ch),
        .ch_ok_o    (ch_ok)
    );

    scr_id_seq #(.SHOW_CYC(ID_SHOW_CYC)) scr_id_seq_inst
    (
        .mclk_i    (mclk_i),
        .nrst_i    (nrst_i),
        .present_i (module_present_i),
        .busy_o    (id_busy),
        .show_o    (id_show_o),
        .slot_o    (id_slot_o)
    );

    // requests wait until the power-up identity display has finished
    assign req_ready_o = !id_busy;
    assign take        = req_valid_i && req_ready_o;
    assign is_close    = take && (req_op_i == scr_pkg::SCR_OP_CLOSE);
    assign is_clear    = take && ((req_op_i == scr_pkg::SCR_OP_OPEN_ALL)
                               || (req_op_i == scr_pkg::SCR_OP_DESELECT));
    assign is_assign   = take && (req_op_i == scr_pkg::SCR_OP_ASSIGN);

    // a real module always takes precedence over a simulated one
    assign occupied = module_present_i | sim_reg;
    assign meas_ok  = (module_present_i & module_meas_i)
                    | (~module_present_i & sim_reg & sim_meas_reg);

    // slot must exist and hold a measurement module; channel must be routable
    assign close_ok = is_close && slot_ok && occupied[slot_idx]
                   && meas_ok[slot_idx] && ch_ok
                   && (!four_wire_i || (ch <= 5'(scr_pkg::PAIR_OFFSET)));

    assign assign_ok = is_assign && req_remote_i
                    && slot_ok && !module_present_i[slot_idx];

    assign req_ok = close_ok || is_clear || assign_ok;

    function automatic logic [NUM_RELAYS-1:0] scr_pattern
    (
        input logic [4:0] ch_in,
        input logic       fw_in
    );
        logic [NUM_RELAYS-1:0] p;
        p = '0;
        p[5'(ch_in - 5'h01)] = 1'b1;
        p[scr_pkg::INPUT_RELAY-1] = 1'b1;
        if (fw_in)
        begin
            p[5'(ch_in + 5'(scr_pkg::PAIR_OFFSET) - 5'h01)] = 1'b1;
            p[scr_pkg::SENSE_RELAY-1] = 1'b1;
            p[scr_pkg::POLE_RELAY-1]  = 1'b1;
        end
        return p;
    endfunction

    // only the addressed slot carries relays, all others open
    genvar gs;
    generate
        for (gs = 0; gs < NUM_SLOTS; gs++)
        begin : g_slot
            assign close_vec[gs*NUM_RELAYS +: NUM_RELAYS] =
                (slot_idx == 3'(gs)) ? scr_pattern(ch, four_wire_i) : '0;
            assign slot_any[gs] = |relay_reg[gs*NUM_RELAYS +: NUM_RELAYS];
            // amps relays have no system-channel use here
            assign spare_any[gs] = relay_reg[gs*NUM_RELAYS + scr_pkg::NUM_MEAS]
                                 | relay_reg[gs*NUM_RELAYS + scr_pkg::NUM_MEAS + 1];
        end
    endgenerate

    always_comb
    begin
        relay_next = relay_reg;
        if (close_ok)
            relay_next = close_vec;
        else if (is_clear)
            relay_next = '0;
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            relay_reg <= '0;
        else
            relay_reg <= relay_next;
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sys_valid_reg <= 1'b0;
            sys_slot_reg  <= 3'h0;
            sys_ch_reg    <= 5'h00;
            sys_4w_reg    <= 1'b0;
            sys_code_reg  <= scr_pkg::CODE_RST;
        end
        else if (close_ok)
        begin
            sys_valid_reg <= 1'b1;
            sys_slot_reg  <= slot_idx;
            sys_ch_reg    <= ch;
            sys_4w_reg    <= four_wire_i;
            sys_code_reg  <= req_code_i;
        end
        else if (is_clear)
        begin
            sys_valid_reg <= 1'b0;
            sys_code_reg  <= scr_pkg::CODE_RST;
        end
    end

    // simulated modules live only in flip-flops, so reset forgets them
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sim_reg      <= scr_pkg::SIM_RST;
            sim_meas_reg <= scr_pkg::SIM_RST;
        end
        else if (assign_ok)
        begin
            sim_reg[slot_idx]      <= 1'b1;
            sim_meas_reg[slot_idx] <= req_sim_meas_i;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            done_reg <= 1'b0;
            ok_reg   <= 1'b0;
        end
        else
        begin
            done_reg <= take;
            ok_reg   <= take && req_ok;
        end
    end

    assign relay_o     = relay_reg;
    assign sys_valid_o = sys_valid_reg;
    assign sys_code_o  = sys_code_reg;
    assign sim_lamp_o  = sim_reg;
    assign req_done_o  = done_reg;
    assign req_ok_o    = ok_reg;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    a_one_sys_slot: assert property ($onehot0(slot_any))
        else $error("relays closed on more than one slot");

    a_no_sys_open: assert property (!sys_valid_reg |-> (relay_reg == '0))
        else $error("relays closed without a system channel");

    a_input_iso: assert property (sys_valid_reg |->
        relay_reg[32'(sys_slot_reg)*NUM_RELAYS + scr_pkg::INPUT_RELAY - 1])
        else $error("input isolation relay open with system channel");

    a_four_wire_set: assert property (close_ok && four_wire_i |=> sys_4w_reg
        && relay_reg[32'(sys_slot_reg)*NUM_RELAYS + scr_pkg::SENSE_RELAY - 1]
        && relay_reg[32'(sys_slot_reg)*NUM_RELAYS + scr_pkg::POLE_RELAY - 1])
        else $error("sense or pole relay missing in four-wire close");

    a_pair_chan: assert property (close_ok && four_wire_i |=>
        relay_reg[32'(sys_slot_reg)*NUM_RELAYS + 32'(sys_ch_reg)
                  + scr_pkg::PAIR_OFFSET - 1])
        else $error("paired channel not closed");

    a_two_wire_no_sense: assert property (sys_valid_reg && !sys_4w_reg |->
        !relay_reg[32'(sys_slot_reg)*NUM_RELAYS + scr_pkg::SENSE_RELAY - 1])
        else $error("sense isolation closed in two-wire mode");

    a_refuse_hold: assert property (take && !req_ok |=> $stable(relay_reg)
        && !req_ok_o && req_done_o)
        else $error("refused request altered relays");

    a_paired_refused: assert property (is_close && four_wire_i && ch_ok
        && (ch > 5'(scr_pkg::PAIR_OFFSET)) |-> !close_ok)
        else $error("paired-bank channel accepted in four-wire mode");

    a_open_all: assert property (is_clear |=> (relay_o == '0) && !sys_valid_o
        && req_ok_o)
        else $error("open-all left relays closed");

    a_sim_occupied: assert property (is_assign && slot_ok
        && module_present_i[slot_idx] |=> $stable(sim_reg) && !req_ok_o)
        else $error("simulated module placed in occupied slot");

    a_sim_local: assert property (is_assign && !req_remote_i |=> $stable(sim_reg))
        else $error("simulated module assigned from front panel");

    a_sim_lamp: assert property (assign_ok |=> sim_lamp_o[$past(slot_idx)])
        else $error("slot lamp not lit after assignment");

    a_slot_digit: assert property (sys_valid_reg |->
        (sys_code_reg[11:8] == 4'(sys_slot_reg + 3'h1)))
        else $error("system code slot digit mismatch");

    a_bad_slot: assert property (is_close && !slot_ok |=> $stable(relay_reg))
        else $error("close with bad slot digit changed relays");

    a_id_block: assert property (id_show_o |-> !req_ready_o ##1 !req_done_o)
        else $error("request taken during identity display");

    a_done_follows: assert property (take |=> req_done_o)
        else $error("taken request not answered");

    a_done_idle: assert property (!take |=> !req_done_o && !req_ok_o)
        else $error("answer without a taken request");

    a_meas_refused: assert property (is_close && slot_ok && !meas_ok[slot_idx]
        |=> $stable(relay_reg) && !req_ok_o)
        else $error("non-measurement slot accepted a close");

    a_empty_refused: assert property (is_close && slot_ok && !occupied[slot_idx]
        |=> $stable(relay_reg) && !req_ok_o)
        else $error("close accepted on an empty slot");

    a_spare_open: assert property (spare_any == '0)
        else $error("amps relay driven by a system channel close");

    a_code_cleared: assert property (!sys_valid_reg |->
        (sys_code_reg == scr_pkg::CODE_RST))
        else $error("system code kept with no system channel");

    a_sys_closed: assert property (sys_valid_reg |->
        relay_reg[32'(sys_slot_reg)*NUM_RELAYS + 32'(sys_ch_reg) - 1])
        else $error("system channel relay open");

    a_sense_held: assert property (sys_valid_reg && sys_4w_reg |->
        relay_reg[32'(sys_slot_reg)*NUM_RELAYS + scr_pkg::SENSE_RELAY - 1])
        else $error("sense isolation open in four-wire mode");

    a_two_wire_pole: assert property (sys_valid_reg && !sys_4w_reg |->
        !relay_reg[32'(sys_slot_reg)*NUM_RELAYS + scr_pkg::POLE_RELAY - 1])
        else $error("pole relay closed in two-wire mode");

    a_four_wire_low: assert property (sys_valid_reg && sys_4w_reg |->
        (sys_ch_reg <= 5'(scr_pkg::PAIR_OFFSET)))
        else $error("four-wire system channel outside the low bank");

    a_new_sys: assert property (close_ok |=> sys_valid_reg
        && (sys_code_reg == $past(req_code_i)) && req_ok_o)
        else $error("closed channel did not become the system channel");

    a_lamp_steady: assert property (!assign_ok |=> $stable(sim_reg))
        else $error("slot lamp changed without an assignment");

    a_walk_clean: assert property ($fell(id_busy) |->
        (relay_reg == '0) && !sys_valid_reg)
        else $error("relays closed during the identity walk");

    a_walk_once: assert property (!id_busy |=> !id_busy)
        else $error("identity walk restarted without reset");

    c_two_wire: cover property (close_ok && !four_wire_i);
    c_four_wire: cover property (close_ok && four_wire_i ##[1:8] is_clear);
    c_refused: cover property (take && !req_ok);
    c_sim_close: cover property (assign_ok ##[1:20] close_ok);
    c_open_all: cover property (sys_valid_reg && is_clear);

endmodule

//--- bench/scr_panel_model.sv
`timescale 1ns/1ps

// stands in for the front panel keys and the remote command interpreter
module scr_panel_model
(
    input  wire logic        mclk_i,
    input  wire logic        req_ready_i,
    input  wire logic        req_done_i,
    input  wire logic        req_ok_i,
    output logic             req_valid_o,
    output logic             req_remote_o,
    output scr_pkg::scr_op_t req_op_o,
    output logic [11:0]      req_code_o,
    output logic             req_sim_meas_o
);
    initial
    begin
        req_valid_o    = 1'b0;
        req_remote_o   = 1'b0;
        req_op_o       = scr_pkg::SCR_OP_CLOSE;
        req_code_o     = 12'h000;
        req_sim_meas_o = 1'b0;
    end

    // one request, held until taken; answer read in the cycle after the take
    task automatic send(input scr_pkg::scr_op_t op, input logic [3:0] slot,
                        input logic [7:0] ch, input logic remote, input logic meas,
                        output logic done, output logic ok);
        int n;
        n = 0;
        @(negedge mclk_i);
        req_valid_o    = 1'b1;
        req_op_o       = op;
        req_code_o     = {slot, ch};
        req_remote_o   = remote;
        req_sim_meas_o = meas;
        // ready only moves on a rising edge, so the falling edge sees it settled
        while (req_ready_i !== 1'b1 && n < 100)
        begin
            @(negedge mclk_i);
            n++;
        end
        @(negedge mclk_i);
        done        = req_done_i;
        ok          = req_ok_i;
        req_valid_o = 1'b0;
        // code is meaningless once released, so it must not look still valid
        req_code_o  = ~req_code_o;
    endtask
endmodule

//--- bench/tb_scr_relay_ctrl.sv
`timescale 1ns/1ps

`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_scr_relay_ctrl;
    logic             mclk_i;
    logic             nrst_i;
    logic             fw;
    logic             rq_valid;
    logic             rq_remote;
    logic             rq_meas;
    logic             rdy;
    logic             done;
    logic             ok;
    logic             sysv;
    logic             ids;
    scr_pkg::scr_op_t rq_op;
    logic [11:0]      rq_code;
    logic [11:0]      sysc;
    logic [4:0]       pres;
    logic [4:0]       meas;
    logic [4:0]       lamp;
    logic [2:0]       idsl;
    logic [124:0]     relay;
    logic [124:0]     exp_rel;
    int               err_count;
    int               n_checks;

    initial
    begin
        mclk_i    = 1'b0;
        nrst_i    = 1'b0;
        fw        = 1'b0;
        pres      = 5'h15;
        meas      = 5'h11;
        err_count = 0;
        n_checks  = 0;
    end

    always #20 mclk_i = ~mclk_i;

    scr_relay_ctrl #(.ID_SHOW_CYC(4)) scr_relay_ctrl_inst
    (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .req_valid_i(rq_valid), .req_remote_i(rq_remote),
        .req_op_i(rq_op), .req_code_i(rq_code), .req_sim_meas_i(rq_meas),
        .four_wire_i(fw), .module_present_i(pres), .module_meas_i(meas),
        .req_ready_o(rdy), .req_done_o(done), .req_ok_o(ok), .relay_o(relay),
        .sys_valid_o(sysv), .sys_code_o(sysc), .sim_lamp_o(lamp),
        .id_show_o(ids), .id_slot_o(idsl)
    );

    scr_panel_model scr_panel_model_inst
    (
        .mclk_i(mclk_i), .req_ready_i(rdy), .req_done_i(done), .req_ok_i(ok),
        .req_valid_o(rq_valid), .req_remote_o(rq_remote), .req_op_o(rq_op),
        .req_code_o(rq_code), .req_sim_meas_o(rq_meas)
    );

    function automatic logic [124:0] rv(input int s, input int c, input logic f);
        logic [124:0] v;
        v = '0;
        v[(s-1)*25 + c - 1] = 1'b1;
        v[(s-1)*25 + scr_pkg::INPUT_RELAY - 1] = 1'b1;
        if (f)
        begin
            v[(s-1)*25 + c + scr_pkg::PAIR_OFFSET - 1] = 1'b1;
            v[(s-1)*25 + scr_pkg::SENSE_RELAY - 1] = 1'b1;
            v[(s-1)*25 + scr_pkg::POLE_RELAY - 1] = 1'b1;
        end
        return v;
    endfunction

    task automatic req(input scr_pkg::scr_op_t op, input logic [3:0] s, input logic [7:0] c,
                       input logic r, input logic m, input logic exp_ok);
        logic d;
        logic k;
        scr_panel_model_inst.send(op, s, c, r, m, d, k);
        `CHK(d, 1'b1)
        `CHK(k, exp_ok)
    endtask

    // reset, then the identity walk: four cycles for each of slots 1, 3, 5
    task automatic t_power;
        int cnt[8];
        int k;
        @(negedge mclk_i);
        nrst_i = 1'b0;
        repeat (12) @(negedge mclk_i);
        `CHK(relay, 125'h0)
        `CHK(lamp, 5'h00)
        nrst_i = 1'b1;
        for (k = 0; k < 100 && rdy !== 1'b1; k++)
        begin
            @(negedge mclk_i);
            if (ids === 1'b1)
                cnt[idsl]++;
        end
        `CHK(cnt[0], 4)
        `CHK(cnt[1], 0)
        `CHK(cnt[2], 4)
        `CHK(cnt[4], 4)
        `CHK(sysv, 1'b0)
        $display("test power done");
    endtask

    task automatic t_two_wire;
        fw = 1'b0;
        req(scr_pkg::SCR_OP_CLOSE, 4'h1, 8'h01, 1'b0, 1'b0, 1'b1);
        `CHK(relay, rv(1, 1, 1'b0))
        `CHK(sysc, 12'h101)
        // slot five, channel twenty: top of both ranges, old channel must drop
        req(scr_pkg::SCR_OP_CLOSE, 4'h5, 8'h20, 1'b1, 1'b0, 1'b1);
        `CHK(relay, rv(5, 20, 1'b0))
        `CHK(sysv, 1'b1)
        `CHK(sysc, 12'h520)
        $display("test two wire done");
    endtask

    task automatic t_four_wire;
        fw = 1'b1;
        req(scr_pkg::SCR_OP_CLOSE, 4'h1, 8'h10, 1'b0, 1'b0, 1'b1);
        exp_rel = rv(1, 10, 1'b1);
        `CHK(relay, exp_rel)
        `CHK(sysc, 12'h110)
        req(scr_pkg::SCR_OP_CLOSE, 4'h1, 8'h11, 1'b0, 1'b0, 1'b0);
        `CHK(relay, exp_rel)
        fw = 1'b0;
        $display("test four wire done");
    endtask

    task automatic t_refuse;
        logic [11:0] bad[7];
        int i;
        bad = '{12'h601, 12'h001, 12'h201, 12'h301, 12'h121, 12'h100, 12'h10a};
        for (i = 0; i < 7; i++)
        begin
            req(scr_pkg::SCR_OP_CLOSE, bad[i][11:8], bad[i][7:0], 1'b1, 1'b0, 1'b0);
            `CHK(relay, exp_rel)
            `CHK(sysc, 12'h110)
        end
        $display("test refuse done");
    endtask

    task automatic t_assign;
        req(scr_pkg::SCR_OP_ASSIGN, 4'h2, 8'h00, 1'b0, 1'b1, 1'b0);
        req(scr_pkg::SCR_OP_ASSIGN, 4'h1, 8'h00, 1'b1, 1'b1, 1'b0);
        `CHK(lamp, 5'h00)
        req(scr_pkg::SCR_OP_ASSIGN, 4'h2, 8'h00, 1'b1, 1'b1, 1'b1);
        `CHK(lamp, 5'h02)
        req(scr_pkg::SCR_OP_CLOSE, 4'h2, 8'h03, 1'b0, 1'b0, 1'b1);
        `CHK(relay, rv(2, 3, 1'b0))
        `CHK(sysc, 12'h203)
        // simulated module with no measurement channels must refuse closes
        req(scr_pkg::SCR_OP_ASSIGN, 4'h4, 8'h00, 1'b1, 1'b0, 1'b1);
        `CHK(lamp, 5'h0a)
        req(scr_pkg::SCR_OP_CLOSE, 4'h4, 8'h01, 1'b1, 1'b0, 1'b0);
        `CHK(relay, rv(2, 3, 1'b0))
        `CHK(sysc, 12'h203)
        $display("test assign done");
    endtask

    task automatic t_open;
        fw = 1'b1;
        req(scr_pkg::SCR_OP_CLOSE, 4'h5, 8'h01, 1'b0, 1'b0, 1'b1);
        req(scr_pkg::SCR_OP_OPEN_ALL, 4'h0, 8'h00, 1'b0, 1'b0, 1'b1);
        `CHK(relay, 125'h0)
        `CHK(sysv, 1'b0)
        req(scr_pkg::SCR_OP_CLOSE, 4'h2, 8'h04, 1'b0, 1'b0, 1'b1);
        req(scr_pkg::SCR_OP_DESELECT, 4'h0, 8'h00, 1'b0, 1'b0, 1'b1);
        `CHK(relay, 125'h0)
        `CHK(sysc, 12'h000)
        fw = 1'b0;
        $display("test open done");
    endtask

    task automatic close_out;
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        t_power();
        t_two_wire();
        t_four_wire();
        t_refuse();
        t_assign();
        t_open();
        // a second power-up must forget the simulated module
        t_power();
        close_out();
    end

    // the whole sequence needs well under a thousand cycles
    initial
    begin
        #(40 * 5000);
        err_count++;
        close_out();
    end
endmodule
